//--- shared/flash_write_resp_pkg.sv
/*
  Constants for the flash-write answer phase of serial programming mode.
  Assumes a byte-level serial link below it; baud timing is handled there.
*/
package flash_write_resp_pkg;
  // Answer bytes
  localparam logic [7:0] FLAG_OK = 8'h55;
  localparam logic [7:0] FLAG_OVERWRITE = 8'hAA;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // Password area that decides a blank part
  localparam logic [15:0] PW_AREA_FIRST = 16'hFFE0;
  localparam logic [15:0] PW_AREA_LAST = 16'hFFFF;
  // Error code is sent this many times
  localparam logic [1:0] ERROR_REPEAT = 2'h3;
  // Address and data widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
endpackage : flash_write_resp_pkg

//--- verilog/flash_byte_store.sv
/*
  Small byte-wide flash image with registered read data.
  Assumes one access per clock; write and read may share a cycle.
*/
module flash_byte_store #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // Clock
  input wire logic i_clock,
  // Write port
  input wire logic i_wr_en,
  input wire logic [ADDR_W-1:0] i_wr_addr,
  input wire logic [DATA_W-1:0] i_wr_data,
  // Read port
  input wire logic [ADDR_W-1:0] i_rd_addr,
  output logic [DATA_W-1:0] o_rd_data
);
  // Storage array, no reset: contents are the memory image
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] rd_data_r;

  ////////////////////////////////////////////////////////////////////////
  // Flash starts erased: every cell reads as all ones, so the first
  // program of a cell is not mistaken for an overwrite
  initial begin
    for (int a = 0; a < (1 << ADDR_W); a++) begin
      mem[a] = '1;
    end
  end

  // Program port; a plain always so the power-up fill may share the array
  always @(posedge i_clock) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read; same-cycle write shows up one access later
  always_ff @(posedge i_clock) begin
    rd_data_r <= mem[i_rd_addr];
  end

  assign o_rd_data = rd_data_r;
endmodule : flash_byte_store

//--- verilog/serial_flash_write_response.sv
/*
  Closing phase of the serial flash-write command: programs received image
  bytes, answers with overwrite flag and checksum, or ends in the idle
  state on password, security or link errors.
  Assumes a byte receiver/transmitter below it already set to the adjusted
  baud rate; earlier command bytes are decoded by the caller.
*/
// Behaviour
// - Both ends keep the adjusted baud rate.
// - Send 0x55 ok or 0xAA on overwrite.
// - Checksum high then low; none on error.
// - After low byte, wait for next command.
// - Error code sent three times, then idle.
// - Blank password area skips authentication; code still checks the password address.
// - Bad password address: error, idle.
// - Security enabled: stop, go idle.
// - Link error during password: go idle.
// - Non-erased target skipped, flag becomes 0xAA.
// - Checksum sums flash contents, not sent data.
module serial_flash_write_response #(
  parameter int ADDR_W = flash_write_resp_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Phase control from command decoder
  input wire logic i_start,
  input wire logic i_pw_addr_ok,
  input wire logic i_pw_blank,
  input wire logic i_pw_string_ok,
  input wire logic i_pw_done,
  input wire logic i_security_on,
  input wire logic i_link_error,
  input wire logic [7:0] i_error_code,
  input wire logic i_error_req,
  // Decoded image bytes
  input wire logic i_img_valid,
  input wire logic [ADDR_W-1:0] i_img_addr,
  input wire logic [7:0] i_img_data,
  input wire logic i_img_end,
  // Checksum span over flash
  input wire logic [ADDR_W-1:0] i_sum_first,
  input wire logic [ADDR_W-1:0] i_sum_last,
  // Byte transmitter
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  // Status
  output logic o_busy,
  output logic o_img_ready,
  output logic o_wait_command,
  output logic o_idle_lock
);
  typedef enum logic [8:0] {
    ST_WAIT  = 9'h001,
    ST_PASS  = 9'h002,
    ST_IMAGE = 9'h004,
    ST_CHECK = 9'h008,
    ST_SUM   = 9'h010,
    ST_FLAG  = 9'h020,
    ST_HIGH  = 9'h040,
    ST_LOW   = 9'h080,
    ST_ERROR = 9'h100
  } state_t;

  state_t state_r, state_nxt;           // Phase sequencer
  logic overwrite_r, overwrite_nxt;     // Sticky overwrite flag
  logic [15:0] sum_r, sum_nxt;          // Running flash checksum
  logic [ADDR_W-1:0] addr_r, addr_nxt;  // Checksum scan address
  logic sum_pipe_r, sum_pipe_nxt;       // Read data valid next cycle
  logic sum_last_r, sum_last_nxt;       // Last read in flight
  logic [1:0] rep_r, rep_nxt;           // Error repeats sent
  logic [7:0] code_r, code_nxt;         // Latched error code
  logic lock_r, lock_nxt;               // Idle until pin reset
  logic [ADDR_W-1:0] wr_addr_r, wr_addr_nxt; // Pending image address
  logic [7:0] wr_data_r, wr_data_nxt;   // Pending image data
  logic wr_en;                          // Program strobe
  logic [ADDR_W-1:0] rd_addr;           // Memory read address
  logic [7:0] rd_data;                  // Registered memory data
  logic [7:0] tx_data_nxt;
  logic [7:0] tx_data_r;

  // Stop all traffic for good
  function automatic logic fatal_cond(input logic sec, input logic lnk);
    fatal_cond = sec | lnk;
  endfunction : fatal_cond

  ////////////////////////////////////////////////////////////////////////
  // Flash image; read data arrive one cycle after the address
  flash_byte_store #(
    .ADDR_W(ADDR_W),
    .DATA_W(flash_write_resp_pkg::DATA_W)
  ) u_store (
    .i_clock(i_clock),
    .i_wr_en(wr_en),
    .i_wr_addr(wr_addr_r),
    .i_wr_data(wr_data_r),
    .i_rd_addr(rd_addr),
    .o_rd_data(rd_data)
  );

  // Read the target during receive, the scan address during summing
  assign rd_addr = (state_r == ST_SUM) ? addr_r : i_img_addr;
  // Write only if the cell still reads erased
  assign wr_en = (state_r == ST_CHECK) &&
                 (rd_data == flash_write_resp_pkg::ERASED_BYTE);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    overwrite_nxt = overwrite_r;
    sum_nxt = sum_r;
    addr_nxt = addr_r;
    sum_pipe_nxt = 1'b0;
    sum_last_nxt = sum_last_r;
    rep_nxt = rep_r;
    code_nxt = code_r;
    lock_nxt = lock_r;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    tx_data_nxt = tx_data_r;
    case (state_r)
      ST_WAIT: begin
        // Only a fresh command leaves the waiting state
        if (i_start) begin
          state_nxt = ST_PASS;
          overwrite_nxt = 1'b0;
        end
      end
      ST_PASS: begin
        if (fatal_cond(i_security_on, i_link_error)) begin
          state_nxt = ST_ERROR;
          lock_nxt = 1'b1;
        end else if (i_pw_done) begin
          // Blank area needs no string, addresses still checked
          if (!i_pw_addr_ok ||
              (!i_pw_blank && !i_pw_string_ok)) begin
            state_nxt = ST_ERROR;
            lock_nxt = 1'b1;
          end else begin
            state_nxt = ST_IMAGE;
          end
        end
      end
      ST_IMAGE: begin
        // Silent while the image streams
        if (i_error_req) begin
          state_nxt = ST_ERROR;
          code_nxt = i_error_code;
          // First copy must stand as soon as valid rises
          tx_data_nxt = i_error_code;
          rep_nxt = 2'h0;
        end else if (i_img_valid) begin
          wr_addr_nxt = i_img_addr;
          wr_data_nxt = i_img_data;
          state_nxt = ST_CHECK;
        end else if (i_img_end) begin
          state_nxt = ST_SUM;
          addr_nxt = i_sum_first;
          sum_nxt = 16'h0000;
          sum_last_nxt = 1'b0;
        end
      end
      ST_CHECK: begin
        // Previous contents now visible on read data
        if (rd_data != flash_write_resp_pkg::ERASED_BYTE) begin
          overwrite_nxt = 1'b1;
        end
        state_nxt = ST_IMAGE;
      end
      ST_SUM: begin
        // Sum what flash holds, skipped cells included
        if (sum_pipe_r) begin
          sum_nxt = sum_r + {8'h00, rd_data};
        end
        if (sum_last_r) begin
          if (sum_pipe_r) begin
            state_nxt = ST_FLAG;
          end
        end else begin
          sum_pipe_nxt = 1'b1;
          if (addr_r == i_sum_last) begin
            sum_last_nxt = 1'b1;
          end else begin
            addr_nxt = addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
          end
        end
        tx_data_nxt = overwrite_r ? flash_write_resp_pkg::FLAG_OVERWRITE
                                  : flash_write_resp_pkg::FLAG_OK;
      end
      ST_FLAG: begin
        if (i_tx_ready) begin
          state_nxt = ST_HIGH;
          tx_data_nxt = sum_nxt[15:8];
        end
      end
      ST_HIGH: begin
        if (i_tx_ready) begin
          state_nxt = ST_LOW;
          tx_data_nxt = sum_r[7:0];
        end
      end
      ST_LOW: begin
        if (i_tx_ready) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_ERROR: begin
        // Requested code sent three times, then locked; password-step entries arrive locked and send none; no checksum follows
        tx_data_nxt = code_r;
        if (!lock_r && i_tx_ready) begin
          rep_nxt = rep_r + 2'h1;
          if (rep_r + 2'h1 == flash_write_resp_pkg::ERROR_REPEAT) begin
            lock_nxt = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = ST_WAIT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers; only reset leaves the locked idle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r <= ST_WAIT;
      overwrite_r <= 1'b0;
      sum_r <= 16'h0000;
      addr_r <= '0;
      sum_pipe_r <= 1'b0;
      sum_last_r <= 1'b0;
      rep_r <= 2'h0;
      code_r <= 8'h00;
      lock_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= 8'h00;
      tx_data_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      overwrite_r <= overwrite_nxt;
      sum_r <= sum_nxt;
      addr_r <= addr_nxt;
      sum_pipe_r <= sum_pipe_nxt;
      sum_last_r <= sum_last_nxt;
      rep_r <= rep_nxt;
      code_r <= code_nxt;
      lock_r <= lock_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      tx_data_r <= tx_data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; transmitter runs at the adjusted rate
  assign o_tx_valid = (state_r == ST_FLAG) || (state_r == ST_HIGH) ||
                      (state_r == ST_LOW) ||
                      ((state_r == ST_ERROR) && !lock_r);
  assign o_tx_data = tx_data_r;
  assign o_busy = (state_r != ST_WAIT);
  assign o_img_ready = (state_r == ST_IMAGE);
  assign o_wait_command = (state_r == ST_WAIT) && !lock_r;
  assign o_idle_lock = lock_r;
endmodule : serial_flash_write_response

//--- verification/flash_resp_chk.sv
/* Assertions on the flash-write answer ports.
   Assumes one clock and a synchronous high reset. */
module flash_resp_chk (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Watched inputs
  input wire logic i_start,
  input wire logic i_pw_addr_ok,
  input wire logic i_pw_done,
  input wire logic i_security_on,
  input wire logic i_link_error,
  input wire logic [7:0] i_error_code,
  input wire logic i_error_req,
  input wire logic i_img_valid,
  input wire logic i_img_end,
  input wire logic i_tx_ready,
  // Watched outputs
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic o_busy,
  input wire logic o_img_ready,
  input wire logic o_wait_command,
  input wire logic o_idle_lock
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // Busy and silent: password step, check cycle or checksum scan; the bench drives the password inputs only in the first
  wire pass_st = o_busy && !o_img_ready && !o_tx_valid && !o_idle_lock;
  a_tx_holds: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data)) else $error("tx byte changed");
  a_image_silent: assert property (o_img_ready |-> !o_tx_valid)
    else $error("tx during image");
  a_lock_holds: assert property (o_idle_lock |->
    !o_tx_valid && !o_wait_command ##1 o_idle_lock) else $error("lock lost");
  a_start_taken: assert property (o_wait_command && i_start |=> o_busy)
    else $error("start not taken");
  a_pw_lock: assert property (pass_st && i_pw_done && !i_pw_addr_ok |=>
    o_idle_lock) else $error("no lock on bad address");
  a_secure_lock: assert property (pass_st && i_security_on |=>
    o_idle_lock) else $error("no lock on security");
  a_link_lock: assert property (pass_st && i_link_error |=>
    o_idle_lock) else $error("no lock on link error");
  a_img_check: assert property (o_img_ready && i_img_valid |=>
    !o_img_ready ##1 o_img_ready) else $error("no check cycle");
  a_flag_due: assert property (
    o_img_ready && i_img_end && !i_img_valid |->
    ##[1:300] o_tx_valid && (o_tx_data == 8'h55 || o_tx_data == 8'hAA))
    else $error("flag missing");
  a_code_sent: assert property (o_img_ready && i_error_req |=>
    o_tx_valid && o_tx_data == $past(i_error_code)) else $error("bad code");
endmodule : flash_resp_chk
////////////////////////////////////////////////////////////////////////
bind serial_flash_write_response flash_resp_chk flash_resp_chk_inst (
  .i_clock(i_clock), .i_reset(i_reset), .i_start(i_start),
  .i_pw_addr_ok(i_pw_addr_ok), .i_pw_done(i_pw_done),
  .i_security_on(i_security_on), .i_link_error(i_link_error),
  .i_error_code(i_error_code), .i_error_req(i_error_req),
  .i_img_valid(i_img_valid), .i_img_end(i_img_end), .i_tx_ready(i_tx_ready),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_busy(o_busy),
  .o_img_ready(o_img_ready), .o_wait_command(o_wait_command),
  .o_idle_lock(o_idle_lock));

//--- verification/tx_sink.sv
/* Byte sink standing for the programming controller.
   Assumes a valid/ready byte handshake at the transmitter. */
module tx_sink (
  // Clock and pacing
  input wire logic i_clock,
  input wire logic i_slow,
  // Transmitter side
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx_q [$]; // Bytes taken, oldest first
  initial o_ready = 1'b0;
  // One byte per handshake at the adjusted rate; random stalls when slow
  always @(posedge i_clock) begin
    if (i_tx_valid === 1'b1 && o_ready === 1'b1) begin
      rx_q.push_back(i_tx_data);
    end
    #1;
    o_ready = !i_slow || ($urandom_range(1) == 1);
  end
endmodule : tx_sink

//--- verification/tb.sv
/* Self-checking bench for the flash-write answer phase.
   Assumes cells not yet written read as erased. */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clock = 0, i_reset = 1, i_start = 0, i_pw_addr_ok = 1, rdy;
  logic i_pw_blank = 0, i_pw_string_ok = 1, i_pw_done = 0, slow = 0;
  logic i_security_on = 0, i_link_error = 0, i_error_req = 0, ovw = 0;
  logic i_img_valid = 0, i_img_end = 0, o_tx_valid, o_busy, o_img_ready;
  logic o_wait_command, o_idle_lock;
  logic [7:0] i_error_code = 8'h00, i_img_data = 8'h00, o_tx_data;
  logic [15:0] i_img_addr = 16'h0000, i_sum_first = 16'h0000;
  logic [15:0] i_sum_last = 16'h0000, s;
  logic [7:0] mem [int]; // Expected flash image
  int num_errors = 0, n_checks = 0, base;
  always #2.5 i_clock = ~i_clock;
  serial_flash_write_response serial_flash_write_response_inst (
    .i_clock(i_clock), .i_reset(i_reset), .i_start(i_start),
    .i_pw_addr_ok(i_pw_addr_ok), .i_pw_blank(i_pw_blank),
    .i_pw_string_ok(i_pw_string_ok), .i_pw_done(i_pw_done),
    .i_security_on(i_security_on), .i_link_error(i_link_error),
    .i_error_code(i_error_code), .i_error_req(i_error_req),
    .i_img_valid(i_img_valid), .i_img_addr(i_img_addr),
    .i_img_data(i_img_data), .i_img_end(i_img_end),
    .i_sum_first(i_sum_first), .i_sum_last(i_sum_last), .i_tx_ready(rdy),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_busy(o_busy),
    .o_img_ready(o_img_ready), .o_wait_command(o_wait_command),
    .o_idle_lock(o_idle_lock));
  tx_sink tx_sink_inst (.i_clock(i_clock), .i_slow(slow),
    .i_tx_valid(o_tx_valid), .i_tx_data(o_tx_data), .o_ready(rdy));
  ////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask : tick
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic g, input logic e);
    chk_byte({7'h00, g}, {7'h00, e});
  endtask : chk_bit
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  // Sum wraps at 16 bits over flash contents, skipped cells included
  function automatic logic [15:0] exp_sum(input int f, input int l);
    exp_sum = 16'h0000;
    for (int a = f; a <= l; a++) begin
      // Cells never written still read as erased
      exp_sum += {8'h00, (mem.exists(a) ? mem[a] : 8'hFF)};
    end
  endfunction : exp_sum
  task automatic wait_q(input int n);
    for (int i = 0; i < 3000 && tx_sink_inst.rx_q.size() < n; i++) tick;
  endtask : wait_q
  task automatic start_pw(input logic ok, bl, st, sc, lk);
    i_pw_addr_ok = ok;
    i_pw_blank = bl;
    i_pw_string_ok = st;
    i_start = 1;
    tick;
    i_start = 0;
    i_security_on = sc;
    i_link_error = lk;
    i_pw_done = 1;
    tick;
    i_pw_done = 0;
    i_security_on = 0;
    i_link_error = 0;
    for (int i = 0; i < 20 && o_img_ready !== 1'b1; i++) tick;
  endtask : start_pw
  // Gap of one cycle between bytes covers the check cycle
  task automatic send_img(input int a, input int d);
    i_img_addr = a[15:0];
    i_img_data = d[7:0];
    i_img_valid = 1;
    tick;
    i_img_valid = 0;
    tick;
    if (!mem.exists(a) || mem[a] == 8'hFF) mem[a] = d[7:0];
    else ovw = 1;
  endtask : send_img
  task automatic finish(input int f, input int l);
    i_sum_first = f[15:0];
    i_sum_last = l[15:0];
    i_img_end = 1;
    tick;
    i_img_end = 0;
    wait_q(3);
    s = exp_sum(f, l);
    chk_byte(tx_sink_inst.rx_q[0], ovw ? 8'hAA : 8'h55);
    chk_byte(tx_sink_inst.rx_q[1], s[15:8]);
    chk_byte(tx_sink_inst.rx_q[2], s[7:0]);
    repeat (4) tick;
    chk_bit(o_wait_command, 1'b1);
    chk_bit(o_busy, 1'b0);
    chk_byte(8'(tx_sink_inst.rx_q.size()), 8'h03);
    tx_sink_inst.rx_q.delete();
    ovw = 0;
  endtask : finish
  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0C9A5B02));
    repeat (3) tick;
    i_reset = 0;
    // Image kept clear of the password area
    base = $urandom_range(16'h7000, 16'h1000);
    start_pw(1, 0, 1, 0, 0);
    for (int i = 0; i < 4; i++) send_img(base + i, $urandom);
    finish(base, base + 3);
    $display("test plain done");
    // Blank part, stalling sink, one rewrite of a used cell
    slow = 1;
    start_pw(1, 1, 0, 0, 0);
    chk_bit(o_img_ready, 1'b1);
    send_img(base + 4, $urandom);
    send_img(base, 8'h5A);
    send_img(base + 5, 8'hFF);
    finish(base, base + 5);
    $display("test overwrite done");
    // Address, string, security, link and coded error paths
    for (int k = 0; k < 5; k++) begin
      start_pw(k != 0, 0, k != 1, k == 2, k == 3);
      if (k == 4) begin
        i_error_code = 8'($urandom);
        i_error_req = 1;
        tick;
        i_error_req = 0;
        wait_q(3);
        for (int j = 0; j < 3; j++) begin
          chk_byte(tx_sink_inst.rx_q[j], i_error_code);
        end
      end
      repeat (4) tick;
      i_start = 1;
      tick;
      i_start = 0;
      tick;
      chk_bit(o_idle_lock, 1'b1);
      chk_byte(8'(tx_sink_inst.rx_q.size()), k == 4 ? 8'h03 : 8'h00);
      tx_sink_inst.rx_q.delete();
      i_reset = 1; // Pin reset is the only way out
      tick;
      i_reset = 0;
      chk_bit(o_wait_command, 1'b1);
      $display("test lock %0d done", k);
    end
    give_verdict;
  end
  // Whole run needs a few thousand cycles at most
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
endmodule : tb
